// ===== logic/wdcops_core.sv
// Execution slice for watchdog clear, complement and decrement-skip
//
// Operation
// - Watchdog clear loads the watchdog counter with zero so the timeout restarts.
// - Watchdog clear also zeroes the prescaler assigned to the watchdog.
// - Watchdog clear sets timeout and sleep-entered flags and leaves other flags alone.
// - Complement (00 1001 d fffffff) inverts the file register and updates the null flag.
// - Complement writes the accumulator when d is 0 and the file register when d is 1.
// - Decrement-skip (00 1011 d fffffff) subtracts one from the file register.
// - Decrement-skip writes the accumulator when d is 0 and the file register when d is 1.
// - A zero decrement result turns the next fetched instruction into a no-operation.
// - A nonzero decrement result lets the next instruction run, one cycle in total.
// - Each instruction cycle is decode, read, process, write; a skip cycle does nothing.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ns
`include "wdcops_regs.svh"
module wdcops_core #(
   parameter int PRESC_W = 8,
   parameter int WDOG_W = 8
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [13:0] instr_word,
   output wdcops_pkg::wdcops_phase_t phase,
   output logic instr_skipped,
   output logic [6:0] file_addr,
   output logic file_rd_en,
   input wire logic [7:0] file_rd_data,
   output logic file_wr_en,
   output logic [7:0] file_wr_data,
   output logic [7:0] accumulator,
   output logic timeout_flag,
   output logic sleep_entered_flag,
   output logic result_null_flag,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata
);
   wdcops_pkg::wdcops_decoded_t dec_q;
   wdcops_pkg::wdcops_result_t alu_res;
   wdcops_pkg::wdcops_result_t res_q;
   logic skip_q;
   logic skipped_q;
   logic [7:0] acc_q;
   logic [7:0] wr_data_q;
   logic wr_en_q;
   logic flag_to_q;
   logic flag_pd_q;
   logic flag_null_q;
   logic [PRESC_W-1:0] presc_q;
   logic [WDOG_W-1:0] wdog_q;
   logic [7:0] rdata_q;
   logic commit;
   logic wdt_clear_now;
   logic sw_status_wr;
   logic sw_acc_wr;

   wdcops_phase_gen u_phase (
      .clock(clock),
      .rstn(rstn),
      .phase(phase)
   );

   wdcops_alu #(.WIDTH(8)) u_alu (
      .op(dec_q.op),
      .operand(file_rd_data),
      .result(alu_res)
   );

   assign commit = (phase == wdcops_pkg::WDCOPS_Q4);
   assign wdt_clear_now = commit && (dec_q.op == wdcops_pkg::WDCOPS_OP_WDT_CLEAR);
   assign sw_status_wr = reg_wr && (reg_addr == `WDCOPS_OFF_STATUS);
   assign sw_acc_wr = reg_wr && (reg_addr == `WDCOPS_OFF_ACCUM);

   // Q1 decode; a pending skip replaces the fetched word with a no-operation
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dec_q <= '0;
      end else if (phase == wdcops_pkg::WDCOPS_Q1) begin
         dec_q.addr <= instr_word[6:0];
         dec_q.dest_file <= instr_word[`WDCOPS_DEST_BIT];
         if (skip_q) begin
            dec_q.op <= wdcops_pkg::WDCOPS_OP_NOP;
         end else if (instr_word == `WDCOPS_WDT_CLEAR_WORD) begin
            dec_q.op <= wdcops_pkg::WDCOPS_OP_WDT_CLEAR;
         end else if (instr_word[13:8] == `WDCOPS_COMPLEMENT_TOP) begin
            dec_q.op <= wdcops_pkg::WDCOPS_OP_COMPLEMENT;
         end else if (instr_word[13:8] == `WDCOPS_DECSKIP_TOP) begin
            dec_q.op <= wdcops_pkg::WDCOPS_OP_DECSKIP;
         end else begin
            dec_q.op <= wdcops_pkg::WDCOPS_OP_NOP;
         end
      end
   end

   // Skip request lives from Q4 of the decrement to Q1 of the next cycle
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         skip_q <= 1'b0;
         skipped_q <= 1'b0;
      end else begin
         if (commit && dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP) begin
            skip_q <= res_q.is_null;
         end else if (phase == wdcops_pkg::WDCOPS_Q1) begin
            skip_q <= 1'b0;
         end
         if (phase == wdcops_pkg::WDCOPS_Q1) begin
            skipped_q <= skip_q;
         end
      end
   end

   // Q2 read of the source register
   assign file_addr = dec_q.addr;
   assign file_rd_en = (phase == wdcops_pkg::WDCOPS_Q2) &&
                       (dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT ||
                        dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP);

   // Q3 process: read data arrives in this phase and is latched
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         res_q <= '0;
      end else if (phase == wdcops_pkg::WDCOPS_Q3) begin
         res_q <= alu_res;
      end
   end

   // Q4 write to file register when the destination bit is set
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wr_en_q <= 1'b0;
         wr_data_q <= 8'h00;
      end else begin
         wr_en_q <= commit && dec_q.dest_file &&
                    (dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT ||
                     dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP);
         if (commit) begin
            wr_data_q <= res_q.value;
         end
      end
   end

   // Accumulator: the instruction write wins over a software write
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         acc_q <= `WDCOPS_RST_ACCUM;
      end else if (commit && !dec_q.dest_file &&
                   (dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT ||
                    dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP)) begin
         acc_q <= res_q.value;
      end else if (sw_acc_wr) begin
         acc_q <= reg_wdata;
      end
   end

   // Status flags: hardware updates take priority over software writes
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         flag_to_q <= 1'(`WDCOPS_RST_STATUS >> `WDCOPS_BIT_TIMEOUT);
         flag_pd_q <= 1'(`WDCOPS_RST_STATUS >> `WDCOPS_BIT_SLEEP);
         flag_null_q <= 1'b0;
      end else begin
         if (wdt_clear_now) begin
            flag_to_q <= 1'b1;
            flag_pd_q <= 1'b1;
         end else if (sw_status_wr) begin
            flag_to_q <= reg_wdata[`WDCOPS_BIT_TIMEOUT];
            flag_pd_q <= reg_wdata[`WDCOPS_BIT_SLEEP];
         end
         // Decrement-skip deliberately leaves the null flag alone
         if (commit && dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT) begin
            flag_null_q <= res_q.is_null;
         end else if (sw_status_wr) begin
            flag_null_q <= reg_wdata[`WDCOPS_BIT_NULL];
         end
      end
   end

   // Watchdog prescaler and counter; timeout handling lives elsewhere
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         presc_q <= '0;
         wdog_q <= '0;
      end else if (wdt_clear_now) begin
         presc_q <= '0;
         wdog_q <= WDOG_W'(`WDCOPS_WDT_CLEARED);
      end else begin
         presc_q <= presc_q + PRESC_W'(1);
         if (presc_q == '1) begin
            wdog_q <= wdog_q + WDOG_W'(1);
         end
      end
   end

   // Register port read: data one cycle after the strobe, zero elsewhere
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 8'h00;
      end else if (reg_rd && reg_addr == `WDCOPS_OFF_STATUS) begin
         rdata_q <= 8'h00;
         rdata_q[`WDCOPS_BIT_TIMEOUT] <= flag_to_q;
         rdata_q[`WDCOPS_BIT_SLEEP] <= flag_pd_q;
         rdata_q[`WDCOPS_BIT_NULL] <= flag_null_q;
      end else if (reg_rd && reg_addr == `WDCOPS_OFF_ACCUM) begin
         rdata_q <= acc_q;
      end else if (reg_rd && reg_addr == `WDCOPS_OFF_WDOG) begin
         rdata_q <= 8'(wdog_q);
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign instr_skipped = skipped_q;
   assign file_wr_en = wr_en_q;
   assign file_wr_data = wr_data_q;
   assign accumulator = acc_q;
   assign timeout_flag = flag_to_q;
   assign sleep_entered_flag = flag_pd_q;
   assign result_null_flag = flag_null_q;
   assign reg_rdata = rdata_q;

   // Checks
   sequence s_decskip_commit;
      commit && dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP;
   endsequence

   sequence s_null_result;
      res_q.is_null;
   endsequence

   property p_wdog_zero;
      @(posedge clock) disable iff (!rstn)
      wdt_clear_now |=> wdog_q == '0;
   endproperty
   a_wdog_zero: assert property (p_wdog_zero) else $error("watchdog not zeroed");

   property p_presc_zero;
      @(posedge clock) disable iff (!rstn)
      wdt_clear_now |=> presc_q == '0 ##1 presc_q == PRESC_W'(1);
   endproperty
   a_presc_zero: assert property (p_presc_zero) else $error("prescaler not restarted");

   property p_flags_set;
      @(posedge clock) disable iff (!rstn)
      wdt_clear_now |=> flag_to_q && flag_pd_q && ($stable(flag_null_q) || $past(sw_status_wr));
   endproperty
   a_flags_set: assert property (p_flags_set) else $error("clear flags wrong");

   property p_comp_value;
      @(posedge clock) disable iff (!rstn)
      phase == wdcops_pkg::WDCOPS_Q3 && dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT
      |=> res_q.value == ~$past(file_rd_data) ##1 flag_null_q == (res_q.value == 8'h00);
   endproperty
   a_comp_value: assert property (p_comp_value) else $error("complement wrong");

   property p_comp_dest;
      @(posedge clock) disable iff (!rstn)
      commit && dec_q.op == wdcops_pkg::WDCOPS_OP_COMPLEMENT && !dec_q.dest_file
      |=> acc_q == $past(res_q.value) && !file_wr_en;
   endproperty
   a_comp_dest: assert property (p_comp_dest) else $error("complement dest wrong");

   property p_dec_value;
      @(posedge clock) disable iff (!rstn)
      phase == wdcops_pkg::WDCOPS_Q3 && dec_q.op == wdcops_pkg::WDCOPS_OP_DECSKIP
      |=> res_q.value == 8'($past(file_rd_data) - 8'h01);
   endproperty
   a_dec_value: assert property (p_dec_value) else $error("decrement wrong");

   property p_dec_dest;
      @(posedge clock) disable iff (!rstn)
      s_decskip_commit ##0 dec_q.dest_file
      |=> file_wr_en && file_wr_data == $past(res_q.value);
   endproperty
   a_dec_dest: assert property (p_dec_dest) else $error("decrement dest wrong");

   property p_skip_nop;
      @(posedge clock) disable iff (!rstn)
      s_decskip_commit ##0 s_null_result
      |=> skip_q ##1 dec_q.op == wdcops_pkg::WDCOPS_OP_NOP && instr_skipped && !file_rd_en;
   endproperty
   a_skip_nop: assert property (p_skip_nop) else $error("skip not taken");

   property p_no_skip;
      @(posedge clock) disable iff (!rstn)
      s_decskip_commit ##0 !res_q.is_null |=> !skip_q ##1 !instr_skipped;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("spurious skip");

   property p_dec_flags;
      @(posedge clock) disable iff (!rstn)
      s_decskip_commit ##0 !sw_status_wr
      |=> $stable(flag_null_q) && $stable(flag_to_q) && $stable(flag_pd_q);
   endproperty
   a_dec_flags: assert property (p_dec_flags) else $error("decrement changed flag");

   property p_phase_order;
      @(posedge clock) disable iff (!rstn)
      phase == wdcops_pkg::WDCOPS_Q1 |=> phase == wdcops_pkg::WDCOPS_Q2
      ##1 phase == wdcops_pkg::WDCOPS_Q3 ##1 phase == wdcops_pkg::WDCOPS_Q4;
   endproperty
   a_phase_order: assert property (p_phase_order) else $error("phase order wrong");
endmodule // wdcops_core

// ===== logic/wdcops_regs.svh
// Constants for the watchdog clear and file register operation slice
`ifndef WDCOPS_REGS_SVH
`define WDCOPS_REGS_SVH
// Instruction encodings
`define WDCOPS_WDT_CLEAR_WORD 14'h0064
`define WDCOPS_COMPLEMENT_TOP 6'h09
`define WDCOPS_DECSKIP_TOP 6'h0b
`define WDCOPS_DEST_BIT 7
// Register port offsets
`define WDCOPS_OFF_STATUS 4'h0
`define WDCOPS_OFF_ACCUM 4'h4
`define WDCOPS_OFF_WDOG 4'h8
// Status field positions
`define WDCOPS_BIT_NULL 0
`define WDCOPS_BIT_SLEEP 3
`define WDCOPS_BIT_TIMEOUT 4
// Reset values and the watchdog clear value
`define WDCOPS_RST_STATUS 8'h18
`define WDCOPS_RST_ACCUM 8'h00
`define WDCOPS_WDT_CLEARED 8'h00
// Phase timing: four clocks per instruction cycle
`define WDCOPS_PHASES 3'h4
`endif

// ===== logic/wdcops_pkg.sv
// Types for the watchdog clear and file register operation slice
package wdcops_pkg;
   typedef enum logic [1:0] {
      WDCOPS_Q1 = 2'b00,
      WDCOPS_Q2 = 2'b01,
      WDCOPS_Q3 = 2'b10,
      WDCOPS_Q4 = 2'b11
   } wdcops_phase_t;
   typedef enum logic [1:0] {
      WDCOPS_OP_NOP = 2'b00,
      WDCOPS_OP_WDT_CLEAR = 2'b01,
      WDCOPS_OP_COMPLEMENT = 2'b10,
      WDCOPS_OP_DECSKIP = 2'b11
   } wdcops_op_t;
   typedef struct packed {
      wdcops_op_t op;
      logic dest_file;
      logic [6:0] addr;
   } wdcops_decoded_t;
   typedef struct packed {
      logic [7:0] value;
      logic is_null;
   } wdcops_result_t;
endpackage

// ===== logic/wdcops_phase_gen.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/1ns
module wdcops_phase_gen (
   input wire logic clock,
   input wire logic rstn,
   output wdcops_pkg::wdcops_phase_t phase
);
   wdcops_pkg::wdcops_phase_t phase_q;

   // Free running: phase order never depends on the instruction
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         phase_q <= wdcops_pkg::WDCOPS_Q1;
      end else begin
         case (phase_q)
            wdcops_pkg::WDCOPS_Q1: phase_q <= wdcops_pkg::WDCOPS_Q2;
            wdcops_pkg::WDCOPS_Q2: phase_q <= wdcops_pkg::WDCOPS_Q3;
            wdcops_pkg::WDCOPS_Q3: phase_q <= wdcops_pkg::WDCOPS_Q4;
            default: phase_q <= wdcops_pkg::WDCOPS_Q1;
         endcase
      end
   end

   assign phase = phase_q;
endmodule // wdcops_phase_gen

// ===== logic/wdcops_alu.sv
// Complement and decrement datapath with null detect
`timescale 1ns/1ns
module wdcops_alu #(
   parameter int WIDTH = 8
) (
   input wdcops_pkg::wdcops_op_t op,
   input wire logic [WIDTH-1:0] operand,
   output wdcops_pkg::wdcops_result_t result
);
   logic [WIDTH-1:0] value;

   always_comb begin
      case (op)
         wdcops_pkg::WDCOPS_OP_COMPLEMENT: value = ~operand;
         wdcops_pkg::WDCOPS_OP_DECSKIP: value = operand - {{(WIDTH-1){1'b0}}, 1'b1};
         default: value = operand;
      endcase
   end

   assign result.value = value;
   assign result.is_null = (value == '0);
endmodule // wdcops_alu

// ===== tb/wdcops_core_tb.sv
// Self-checking bench for the watchdog clear, complement and decrement-skip slice
`timescale 1ns/1ns
module wdcops_core_tb;
   typedef struct {
      logic [13:0] word;
      logic [7:0] fdata;
      logic [7:0] res;
      logic null_after;
   } wdcops_row_t;
   logic clock;
   logic rstn;
   logic [13:0] instr_word;
   logic [7:0] file_rd_data;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   wdcops_pkg::wdcops_phase_t phase;
   logic instr_skipped;
   logic [6:0] file_addr;
   logic file_rd_en;
   logic file_wr_en;
   logic [7:0] file_wr_data;
   logic [7:0] accumulator;
   logic timeout_flag;
   logic sleep_entered_flag;
   logic result_null_flag;
   logic [7:0] reg_rdata;
   logic [7:0] rd_val;
   logic [7:0] acc_seen;
   int err_total = 0;
   int num_checks = 0;
   // Decrement rows keep the null flag of the complement row before them
   wdcops_row_t rows [7] = '{
      '{14'h0985, 8'h13, 8'hec, 1'b0},
      '{14'h0905, 8'hff, 8'h00, 1'b1},
      '{14'h0b8a, 8'h05, 8'h04, 1'b1},
      '{14'h0b0a, 8'h80, 8'h7f, 1'b1},
      '{14'h0b7f, 8'h00, 8'hff, 1'b1},
      '{14'h09ff, 8'h00, 8'hff, 1'b0},
      '{14'h0b00, 8'h02, 8'h01, 1'b0}
   };

   // Short prescaler so the watchdog counter moves within a short run
   wdcops_core #(.PRESC_W(2), .WDOG_W(8)) DUT (
      .clock(clock),
      .rstn(rstn),
      .instr_word(instr_word),
      .phase(phase),
      .instr_skipped(instr_skipped),
      .file_addr(file_addr),
      .file_rd_en(file_rd_en),
      .file_rd_data(file_rd_data),
      .file_wr_en(file_wr_en),
      .file_wr_data(file_wr_data),
      .accumulator(accumulator),
      .timeout_flag(timeout_flag),
      .sleep_entered_flag(sleep_entered_flag),
      .result_null_flag(result_null_flag),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata)
   );

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic final_report();
      $display("Checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [3:0] addr, input logic [7:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_wdata <= data;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Data is taken only in the single cycle after the strobe
   task automatic reg_read(input logic [3:0] addr, output logic [7:0] data);
      @(posedge clock);
      reg_addr <= addr;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      data = reg_rdata;
   endtask

   // Presents word in Q1, returns one step into the next Q1 where results show
   task automatic run_instr(input logic [13:0] word, input logic [7:0] fdata,
                            input logic [13:0] nxt, input logic rd_exp);
      int n;
      n = 0;
      while (phase !== wdcops_pkg::WDCOPS_Q4) begin
         @(posedge clock);
         #1;
         n++;
         if (n > 8) begin
            err_total++;
            $display("CHECK FAILED at %0t: phase does not advance", $time);
            final_report();
         end
      end
      @(posedge clock);
      instr_word <= word;
      file_rd_data <= fdata;
      @(posedge clock);
      instr_word <= nxt;
      #1;
      chk({6'h00, phase}, 8'h01);
      chk({7'h00, file_rd_en}, {7'h00, rd_exp});
      if (rd_exp) begin
         chk({1'b0, file_addr}, {1'b0, word[6:0]});
      end
      repeat (3) @(posedge clock);
      #1;
   endtask

   initial begin
      repeat (20000) @(posedge clock);
      err_total++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      final_report();
   end

   initial begin
      rstn = 1'b0;
      instr_word = 14'h0000;
      file_rd_data = 8'h00;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      chk({7'h00, file_rd_en}, 8'h00);
      @(posedge clock);
      rstn <= 1'b1;
      reg_read(4'h0, rd_val);
      chk(rd_val, 8'h18);
      reg_read(4'h4, rd_val);
      chk(rd_val, 8'h00);
      foreach (rows[i]) begin
         run_instr(rows[i].word, rows[i].fdata, 14'h0000, 1'b1);
         if (rows[i].word[7]) begin
            chk({7'h00, file_wr_en}, 8'h01);
            chk(file_wr_data, rows[i].res);
         end else begin
            chk({7'h00, file_wr_en}, 8'h00);
            chk(accumulator, rows[i].res);
         end
         chk({7'h00, result_null_flag}, {7'h00, rows[i].null_after});
         @(posedge clock);
         #1;
         chk({7'h00, instr_skipped}, 8'h00);
      end
      // Zero result: the complement fetched behind it must never reach the accumulator
      run_instr(14'h0b85, 8'h01, 14'h0905, 1'b1);
      chk(file_wr_data, 8'h00);
      chk({7'h00, result_null_flag}, 8'h00);
      acc_seen = accumulator;
      @(posedge clock);
      instr_word <= 14'h0000;
      #1;
      chk({7'h00, instr_skipped}, 8'h01);
      chk({7'h00, file_rd_en}, 8'h00);
      repeat (3) @(posedge clock);
      #1;
      chk({7'h00, instr_skipped}, 8'h01);
      chk(accumulator, acc_seen);
      @(posedge clock);
      #1;
      chk({7'h00, instr_skipped}, 8'h00);
      // Register port: read-write accumulator, unmapped place
      reg_write(4'h4, 8'ha5);
      reg_read(4'h4, rd_val);
      chk(rd_val, 8'ha5);
      chk(accumulator, 8'ha5);
      reg_write(4'hc, 8'h77);
      reg_read(4'hc, rd_val);
      chk(rd_val, 8'h00);
      // Watchdog clear after the counter has run for a while
      reg_read(4'h8, rd_val);
      chk({7'h00, rd_val != 8'h00}, 8'h01);
      reg_write(4'h0, 8'h01);
      reg_read(4'h0, rd_val);
      chk(rd_val, 8'h01);
      run_instr(14'h0064, 8'h5a, 14'h0000, 1'b0);
      chk({7'h00, timeout_flag}, 8'h01);
      chk({7'h00, sleep_entered_flag}, 8'h01);
      chk(accumulator, 8'ha5);
      reg_read(4'h8, rd_val);
      chk(rd_val, 8'h00);
      reg_read(4'h8, rd_val);
      chk(rd_val, 8'h00);
      // Restarted prescaler wraps four clocks after the clear, so one count by now
      reg_read(4'h8, rd_val);
      chk(rd_val, 8'h01);
      reg_read(4'h0, rd_val);
      chk(rd_val, 8'h19);
      final_report();
   end
endmodule // wdcops_core_tb
